// file: dscr_top.sv
// Purpose: externally viewed debug status and control register
// Assumes: coprocessor access fields arrive synchronous to clk_in
// Notes: rst_in is the warm reset; cold reset also drives it
`timescale 1ns/1ps
`include "dscr_defines.svh"

module dscr_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // coprocessor access
  input wire logic cp_valid_in,
  input wire logic cp_write_in,
  input wire logic [3:0] cp_num_in,
  input wire logic [2:0] cp_opc1_in,
  input wire logic [2:0] cp_opc2_in,
  input wire logic [3:0] cp_crn_in,
  input wire logic [3:0] cp_crm_in,
  input wire logic [31:0] cp_wdata_in,
  input wire logic [1:0] el_in,
  output logic cp_ack_out,
  output logic [31:0] cp_rdata_out,
  output logic cp_undef_out,
  output logic cp_hyp_trap_out,
  // hypervisor and lock state
  input wire logic el2_present_in,
  input wire logic hyp_debug_access_trap_in,
  input wire logic os_lock_state_in,
  // live external debug status fields
  input wire logic inbound_buffer_occupied_in,
  input wire logic outbound_buffer_occupied_in,
  input wire logic inbound_overrun_flag_in,
  input wire logic outbound_underrun_flag_in,
  input wire logic [1:0] interrupt_disable_copy_in,
  input wire logic debug_access_trap_copy_in,
  input wire logic halting_enable_copy_in,
  input wire logic sticky_error_in,
  // restore path into the external debug status register
  output logic restore_strobe_out,
  output logic inbound_buffer_occupied_out,
  output logic outbound_buffer_occupied_out,
  output logic inbound_overrun_flag_out,
  output logic outbound_underrun_flag_out,
  output logic [1:0] interrupt_disable_copy_out,
  output logic debug_access_trap_copy_out,
  output logic halting_enable_copy_out,
  output logic sticky_error_out,
  // debug events
  input wire logic sw_software_breakpoint_instruction_in,
  input wire logic software_breakpoint_instruction_hit_in,
  input wire logic vcatch_hit_in,
  input wire logic watch_hit_in,
  output logic dbg_exc_take_out,
  output logic [3:0] dbg_exc_code_out,
  // user-level comms access check
  input wire logic comms_valid_in,
  input wire dscr_pkg::dscr_target_t comms_target_in,
  input wire dscr_pkg::dscr_form_t comms_form_in,
  input wire logic debug_state_in,
  output logic comms_undef_out,
  // control state seen by the rest of the core
  output logic monitor_debug_enable_out,
  output logic user_comms_trap_out
);
  import dscr_pkg::*;

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  logic monitor_debug_enable;
  logic user_comms_trap;
  logic [3:0] entry_method_code;

  logic hit;
  logic hyp_trap;
  logic el0_undef;
  logic accept;
  logic wr;
  logic rd;
  logic take;
  logic [3:0] next_code;
  logic [31:0] view;

  // ----------------------------------------------------------
  // access decode
  // ----------------------------------------------------------
  // fixed coprocessor encoding selects this register
  assign hit = cp_valid_in &&
               (cp_num_in == `DSCR_CP_NUM) &&
               (cp_opc1_in == `DSCR_OPC1) &&
               (cp_opc2_in == `DSCR_OPC2) &&
               (cp_crn_in == `DSCR_CRN) &&
               (cp_crm_in == `DSCR_CRM);

  // not reachable from the lowest level at all
  assign el0_undef = hit && (el_in == `DSCR_EL0);

  // hyp trap wins over the access; state is left untouched
  assign hyp_trap = hit && el2_present_in && hyp_debug_access_trap_in &&
                    (el_in == `DSCR_EL1);

  assign accept = hit && !el0_undef && !hyp_trap;
  assign wr = accept && cp_write_in;
  assign rd = accept && !cp_write_in;

  // ----------------------------------------------------------
  // read view
  // ----------------------------------------------------------
  // mirrors show the live external fields, so after any reset they
  // return whatever the external register itself holds
  always_comb begin
    view = `DSCR_ZERO_WORD;
    view[`DSCR_INBOUND_BUFFER_OCCUPIED_BIT] = inbound_buffer_occupied_in;
    view[`DSCR_OUTBOUND_BUFFER_OCCUPIED_BIT] = outbound_buffer_occupied_in;
    view[`DSCR_RXO_BIT] = inbound_overrun_flag_in;
    view[`DSCR_TXU_BIT] = outbound_underrun_flag_in;
    view[`DSCR_INTERRUPT_DISABLE_COPY_HI:`DSCR_INTERRUPT_DISABLE_COPY_LO] =
      interrupt_disable_copy_in;
    view[`DSCR_TDA_BIT] = debug_access_trap_copy_in;
    view[`DSCR_NS_BIT] = 1'b1;
    view[`DSCR_SPNID_BIT] = 1'b0;
    view[`DSCR_SPID_BIT] = 1'b0;
    view[`DSCR_MDBG_BIT] = monitor_debug_enable;
    view[`DSCR_HDE_BIT] = halting_enable_copy_in;
    view[`DSCR_UDCC_BIT] = user_comms_trap;
    view[`DSCR_ERR_BIT] = sticky_error_in;
    view[`DSCR_MOE_HI:`DSCR_MOE_LO] = entry_method_code;
  end

  // ----------------------------------------------------------
  // access response
  // ----------------------------------------------------------
  // one-cycle registered answer to every request that decodes here
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cp_ack_out <= 1'b0;
      cp_undef_out <= 1'b0;
      cp_hyp_trap_out <= 1'b0;
    end else begin
      cp_ack_out <= accept;
      cp_undef_out <= el0_undef;
      cp_hyp_trap_out <= hyp_trap;
    end
  end

  // read data holds until the next accepted read
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cp_rdata_out <= `DSCR_ZERO_WORD;
    end else if (rd) begin
      cp_rdata_out <= view;
    end
  end

  // ----------------------------------------------------------
  // monitor enable and comms trap
  // ----------------------------------------------------------
  // warm reset clears both control bits
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      monitor_debug_enable <= 1'b0;
      user_comms_trap <= 1'b0;
    end else if (wr) begin
      monitor_debug_enable <= cp_wdata_in[`DSCR_MDBG_BIT];
      user_comms_trap <= cp_wdata_in[`DSCR_UDCC_BIT];
    end
  end

  assign monitor_debug_enable_out = monitor_debug_enable;
  assign user_comms_trap_out = user_comms_trap;

  // ----------------------------------------------------------
  // entry method code
  // ----------------------------------------------------------
  dscr_moe_encode u_moe (
    .sw_software_breakpoint_instruction_in(sw_software_breakpoint_instruction_in),
    .software_breakpoint_instruction_hit_in(software_breakpoint_instruction_hit_in),
    .vcatch_hit_in(vcatch_hit_in),
    .watch_hit_in(watch_hit_in),
    .monitor_debug_enable_in(monitor_debug_enable),
    .take_out(take),
    .code_out(next_code)
  );

  // software may write it too; an exception in the same cycle wins
  // because it carries fresh hardware state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      entry_method_code <= `DSCR_MOE_RESET;
    end else if (take) begin
      entry_method_code <= next_code;
    end else if (wr) begin
      entry_method_code <= cp_wdata_in[`DSCR_MOE_HI:`DSCR_MOE_LO];
    end
  end

  // exception request registered alongside its code
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dbg_exc_take_out <= 1'b0;
      dbg_exc_code_out <= `DSCR_MOE_RESET;
    end else begin
      dbg_exc_take_out <= take;
      dbg_exc_code_out <= next_code;
    end
  end

  // ----------------------------------------------------------
  // save and restore of the external status
  // ----------------------------------------------------------
  // restore only while locked; unlocked writes leave mirrors alone
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      restore_strobe_out <= 1'b0;
    end else begin
      restore_strobe_out <= wr && os_lock_state_in;
    end
  end

  // restore values stand until the next locked write
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      inbound_buffer_occupied_out <= 1'b0;
      outbound_buffer_occupied_out <= 1'b0;
      inbound_overrun_flag_out <= 1'b0;
      outbound_underrun_flag_out <= 1'b0;
      interrupt_disable_copy_out <= 2'h_0;
      debug_access_trap_copy_out <= 1'b0;
      halting_enable_copy_out <= 1'b0;
      sticky_error_out <= 1'b0;
    end else if (wr && os_lock_state_in) begin
      inbound_buffer_occupied_out <=
        cp_wdata_in[`DSCR_INBOUND_BUFFER_OCCUPIED_BIT];
      outbound_buffer_occupied_out <=
        cp_wdata_in[`DSCR_OUTBOUND_BUFFER_OCCUPIED_BIT];
      inbound_overrun_flag_out <= cp_wdata_in[`DSCR_RXO_BIT];
      outbound_underrun_flag_out <= cp_wdata_in[`DSCR_TXU_BIT];
      interrupt_disable_copy_out <=
        cp_wdata_in[`DSCR_INTERRUPT_DISABLE_COPY_HI:`DSCR_INTERRUPT_DISABLE_COPY_LO];
      debug_access_trap_copy_out <= cp_wdata_in[`DSCR_TDA_BIT];
      halting_enable_copy_out <= cp_wdata_in[`DSCR_HDE_BIT];
      sticky_error_out <= cp_wdata_in[`DSCR_ERR_BIT];
    end
  end

  // ----------------------------------------------------------
  // user-level comms trap
  // ----------------------------------------------------------
  // combinational so the core can raise Undefined in the same cycle
  dscr_trap_check u_trap (
    .valid_in(comms_valid_in),
    .target_in(comms_target_in),
    .form_in(comms_form_in),
    .el_in(el_in),
    .debug_state_in(debug_state_in),
    .user_comms_trap_in(user_comms_trap),
    .undef_trap_out(comms_undef_out)
  );

endmodule

// file: dscr_defines.svh
// Purpose: named constants of the debug status and control register
// Assumes: one 32-bit register on a coprocessor access port
// Notes: bit positions, codes and access encoding only
`ifndef DSCR_DEFINES_SVH
`define DSCR_DEFINES_SVH

// ----------------------------------------------------------
// access encoding
// ----------------------------------------------------------
`define DSCR_CP_NUM 4'h_e
`define DSCR_OPC1 3'h_0
`define DSCR_OPC2 3'h_2
`define DSCR_CRN 4'h_0
`define DSCR_CRM 4'h_2

// ----------------------------------------------------------
// field positions
// ----------------------------------------------------------
`define DSCR_INBOUND_BUFFER_OCCUPIED_BIT 30
`define DSCR_OUTBOUND_BUFFER_OCCUPIED_BIT 29
`define DSCR_RXO_BIT 27
`define DSCR_TXU_BIT 26
`define DSCR_INTERRUPT_DISABLE_COPY_HI 23
`define DSCR_INTERRUPT_DISABLE_COPY_LO 22
`define DSCR_TDA_BIT 21
`define DSCR_NS_BIT 18
`define DSCR_SPNID_BIT 17
`define DSCR_SPID_BIT 16
`define DSCR_MDBG_BIT 15
`define DSCR_HDE_BIT 14
`define DSCR_UDCC_BIT 12
`define DSCR_ERR_BIT 6
`define DSCR_MOE_HI 5
`define DSCR_MOE_LO 2

// ----------------------------------------------------------
// values
// ----------------------------------------------------------
`define DSCR_ZERO_WORD 32'h_0000_0000
`define DSCR_MOE_RESET 4'h_0
`define DSCR_MOE_SOFTWARE_BREAKPOINT_INSTRUCTION 4'h_1
`define DSCR_MOE_SWBKPT 4'h_3
`define DSCR_MOE_VCATCH 4'h_5
`define DSCR_MOE_WATCH 4'h_a
`define DSCR_EL0 2'h_0
`define DSCR_EL1 2'h_1

`endif

// file: dscr_pkg.sv
// Purpose: shared types of the debug status and control block
// Assumes: nothing beyond the defines header
// Notes: types only; numbers live in dscr_defines.svh
package dscr_pkg;

  // user-level comms registers that the trap covers, plus DSCR_TGT_OTHER for accesses it leaves alone
  typedef enum logic [2:0] {
    DSCR_TGT_INT_STATUS,
    DSCR_TGT_INBOUND,
    DSCR_TGT_OUTBOUND,
    DSCR_TGT_ID,
    DSCR_TGT_SELF_ADDR,
    DSCR_TGT_ROM_ADDR,
    DSCR_TGT_OTHER
  } dscr_target_t;

  // form of the instruction making a comms access
  typedef enum logic [1:0] {
    DSCR_FORM_SINGLE,
    DSCR_FORM_DOUBLE,
    DSCR_FORM_LOAD_STORE
  } dscr_form_t;

endpackage

// file: dscr_moe_encode.sv
// Purpose: gates debug events and encodes the entry method code
// Assumes: event inputs are one-cycle requests
// Notes: combinational; priority sw breakpoint, breakpoint, vcatch, watch
`timescale 1ns/1ps
`include "dscr_defines.svh"

module dscr_moe_encode (
  // event requests
  input wire logic sw_software_breakpoint_instruction_in,
  input wire logic software_breakpoint_instruction_hit_in,
  input wire logic vcatch_hit_in,
  input wire logic watch_hit_in,
  // control
  input wire logic monitor_debug_enable_in,
  // result
  output logic take_out,
  output logic [3:0] code_out
);

  // ----------------------------------------------------------
  // selection
  // ----------------------------------------------------------
  // the sw breakpoint is not a monitor event, so never gated
  always_comb begin
    take_out = 1'b0;
    code_out = `DSCR_MOE_RESET;
    if (sw_software_breakpoint_instruction_in) begin
      take_out = 1'b1;
      code_out = `DSCR_MOE_SWBKPT;
    end else if (monitor_debug_enable_in) begin
      if (software_breakpoint_instruction_hit_in) begin
        take_out = 1'b1;
        code_out = `DSCR_MOE_SOFTWARE_BREAKPOINT_INSTRUCTION;
      end else if (vcatch_hit_in) begin
        take_out = 1'b1;
        code_out = `DSCR_MOE_VCATCH;
      end else if (watch_hit_in) begin
        take_out = 1'b1;
        code_out = `DSCR_MOE_WATCH;
      end
    end
  end

endmodule

// file: dscr_trap_check.sv
// Purpose: user-level trap check on the debug comms registers
// Assumes: exception level and debug state are stable with the request
// Notes: combinational
`timescale 1ns/1ps
`include "dscr_defines.svh"

module dscr_trap_check (
  // request
  input wire logic valid_in,
  input wire dscr_pkg::dscr_target_t target_in,
  input wire dscr_pkg::dscr_form_t form_in,
  input wire logic [1:0] el_in,
  input wire logic debug_state_in,
  // control
  input wire logic user_comms_trap_in,
  // result
  output logic undef_trap_out
);
  import dscr_pkg::*;

  logic covered;
  logic transfer_reg;

  // ----------------------------------------------------------
  // decode
  // ----------------------------------------------------------
  // every instruction form is trapped alike, so form is not a term
  always_comb begin
    covered = (target_in != DSCR_TGT_OTHER);
    transfer_reg = (target_in == DSCR_TGT_INBOUND) ||
                   (target_in == DSCR_TGT_OUTBOUND);
  end

  // transfer register traps drop out in debug state only
  assign undef_trap_out = valid_in && user_comms_trap_in && covered &&
                          (el_in == `DSCR_EL0) &&
                          !(debug_state_in && transfer_reg);

endmodule

// file: dscr_top_monitor.sv
// Purpose: concurrent checks on the debug status register ports
// Assumes: one clock, async active-high reset
// Notes: bound to dscr_top by the bind at the foot of this file
`timescale 1ns/1ps
`include "dscr_defines.svh"

module dscr_top_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register access
  input wire logic cp_valid_in,
  input wire logic cp_write_in,
  input wire logic [3:0] cp_num_in,
  input wire logic [2:0] cp_opc1_in,
  input wire logic [2:0] cp_opc2_in,
  input wire logic [3:0] cp_crn_in,
  input wire logic [3:0] cp_crm_in,
  input wire logic [31:0] cp_wdata_in,
  input wire logic [1:0] el_in,
  input wire logic cp_ack_out,
  input wire logic [31:0] cp_rdata_out,
  input wire logic cp_undef_out,
  input wire logic cp_hyp_trap_out,
  input wire logic el2_present_in,
  input wire logic hyp_debug_access_trap_in,
  input wire logic os_lock_state_in,
  input wire logic restore_strobe_out,
  input wire logic inbound_buffer_occupied_out,
  // events and comms
  input wire logic sw_software_breakpoint_instruction_in,
  input wire logic software_breakpoint_instruction_hit_in,
  input wire logic dbg_exc_take_out,
  input wire logic [3:0] dbg_exc_code_out,
  input wire logic comms_valid_in,
  input wire dscr_pkg::dscr_target_t comms_target_in,
  input wire logic debug_state_in,
  input wire logic comms_undef_out,
  input wire logic monitor_debug_enable_out,
  input wire logic user_comms_trap_out
);
  import dscr_pkg::*;
  logic hit, hyp, ok, dcc;
  // decode of one access; a refused access must never be acknowledged
  assign hit = cp_valid_in && cp_num_in == `DSCR_CP_NUM &&
    cp_opc1_in == `DSCR_OPC1 && cp_opc2_in == `DSCR_OPC2 &&
    cp_crn_in == `DSCR_CRN && cp_crm_in == `DSCR_CRM;
  assign hyp = el_in == `DSCR_EL1 && el2_present_in &&
    hyp_debug_access_trap_in;
  assign ok = hit && el_in != `DSCR_EL0 && !hyp;
  assign dcc = comms_target_in == DSCR_TGT_INBOUND ||
    comms_target_in == DSCR_TGT_OUTBOUND;

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_ack;
    ok |=> cp_ack_out && !cp_undef_out && !cp_hyp_trap_out;
  endproperty
  a_ack: assert property (p_ack) else $error("access not acked");
  property p_undef;
    hit && el_in == `DSCR_EL0 |=> cp_undef_out && !cp_ack_out;
  endproperty
  a_undef: assert property (p_undef) else $error("el0 not refused");
  property p_hyp;
    hit && hyp |=> cp_hyp_trap_out && !cp_ack_out;
  endproperty
  a_hyp: assert property (p_hyp) else $error("hyp trap missing");
  property p_view;
    ok && !cp_write_in |=>
      (cp_rdata_out & 32'h_131F_2F83) == 32'h_0004_0000;
  endproperty
  a_view: assert property (p_view)
    else $error("fixed bits wrong");
  property p_lock;
    ok && cp_write_in && os_lock_state_in |=> restore_strobe_out &&
      inbound_buffer_occupied_out == $past(cp_wdata_in[30]);
  endproperty
  a_lock: assert property (p_lock) else $error("restore missing");
  property p_unlock;
    ok && cp_write_in && !os_lock_state_in |=> !restore_strobe_out;
  endproperty
  a_unlock: assert property (p_unlock) else $error("bad restore");
  property p_ctl;
    ok && cp_write_in |=>
      monitor_debug_enable_out == $past(cp_wdata_in[15]) &&
      user_comms_trap_out == $past(cp_wdata_in[12]);
  endproperty
  a_ctl: assert property (p_ctl)
    else $error("control not written");
  property p_software_breakpoint_instruction;
    software_breakpoint_instruction_hit_in && !sw_software_breakpoint_instruction_in && monitor_debug_enable_out |=>
      dbg_exc_take_out && dbg_exc_code_out == `DSCR_MOE_SOFTWARE_BREAKPOINT_INSTRUCTION;
  endproperty
  a_software_breakpoint_instruction: assert property (p_software_breakpoint_instruction) else $error("software_breakpoint_instruction code wrong");
  property p_gate;
    !sw_software_breakpoint_instruction_in && !monitor_debug_enable_out |=> !dbg_exc_take_out;
  endproperty
  a_gate: assert property (p_gate) else $error("gated event taken");
  property p_comms;
    comms_valid_in && user_comms_trap_out && el_in == `DSCR_EL0 &&
      !debug_state_in && comms_target_in != DSCR_TGT_OTHER
      |-> comms_undef_out;
  endproperty
  a_comms: assert property (p_comms)
    else $error("comms not trapped");
  property p_dstate;
    debug_state_in && dcc |-> !comms_undef_out;
  endproperty
  a_dstate: assert property (p_dstate) else $error("debug state trap");
  // main scenarios reached
  c_lock: cover property (ok && cp_write_in && os_lock_state_in);
  c_take: cover property (dbg_exc_take_out);
  c_comms: cover property (comms_undef_out);
endmodule

bind dscr_top dscr_top_monitor u_mon (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .cp_valid_in(cp_valid_in),
  .cp_write_in(cp_write_in),
  .cp_num_in(cp_num_in),
  .cp_opc1_in(cp_opc1_in),
  .cp_opc2_in(cp_opc2_in),
  .cp_crn_in(cp_crn_in),
  .cp_crm_in(cp_crm_in),
  .cp_wdata_in(cp_wdata_in),
  .el_in(el_in),
  .cp_ack_out(cp_ack_out),
  .cp_rdata_out(cp_rdata_out),
  .cp_undef_out(cp_undef_out),
  .cp_hyp_trap_out(cp_hyp_trap_out),
  .el2_present_in(el2_present_in),
  .hyp_debug_access_trap_in(hyp_debug_access_trap_in),
  .os_lock_state_in(os_lock_state_in),
  .restore_strobe_out(restore_strobe_out),
  .inbound_buffer_occupied_out(inbound_buffer_occupied_out),
  .sw_software_breakpoint_instruction_in(sw_software_breakpoint_instruction_in),
  .software_breakpoint_instruction_hit_in(software_breakpoint_instruction_hit_in),
  .dbg_exc_take_out(dbg_exc_take_out),
  .dbg_exc_code_out(dbg_exc_code_out),
  .comms_valid_in(comms_valid_in),
  .comms_target_in(comms_target_in),
  .debug_state_in(debug_state_in),
  .comms_undef_out(comms_undef_out),
  .monitor_debug_enable_out(monitor_debug_enable_out),
  .user_comms_trap_out(user_comms_trap_out)
);

// file: dscr_top_test.sv
// Purpose: self-checking bench for the debug status register
// Assumes: inputs driven at falling edge, answers one cycle later
// Notes: expected answers queued by drivers, checked by a watcher
`timescale 1ns/1ps
`include "dscr_defines.svh"

module dscr_top_test;
  import dscr_pkg::*;
  localparam logic [17:0] HIT = 18'h_3_8202;
  logic clk_in = 1'h0, rst_in = 1'h1, cp_valid_in = 1'h0;
  logic cp_write_in = 1'h0, el2 = 1'h0, hyptr = 1'h0, lock = 1'h0;
  logic comms_valid_in = 1'h0, debug_state_in = 1'h0;
  logic mdbg, udcc;
  logic [1:0] el_in = 2'h0;
  logic [3:0] ev = 4'h0, moe;
  logic [8:0] live = 9'h000, rsf;
  logic [17:0] enc = 18'h0_0000;
  logic [31:0] cp_wdata_in = 32'h_0000_0000;
  logic [35:0] e;
  dscr_target_t comms_target_in = DSCR_TGT_OTHER;
  dscr_form_t comms_form_in = DSCR_FORM_SINGLE;
  wire cp_ack_out, cp_undef_out, cp_hyp_trap_out, restore_strobe_out;
  wire dbg_exc_take_out, comms_undef_out, mden, uct;
  wire [3:0] dbg_exc_code_out;
  wire [8:0] ro;
  wire [31:0] cp_rdata_out;
  logic [35:0] e_q[$];
  logic [3:0] x_q[$];
  int err_count = 0, compares = 0;

  dscr_top u_dut (.clk_in(clk_in), .rst_in(rst_in),
    .cp_valid_in(cp_valid_in), .cp_write_in(cp_write_in),
    .cp_num_in(enc[17:14]), .cp_opc1_in(enc[13:11]),
    .cp_opc2_in(enc[10:8]), .cp_crn_in(enc[7:4]), .cp_crm_in(enc[3:0]),
    .cp_wdata_in(cp_wdata_in), .el_in(el_in), .cp_ack_out(cp_ack_out),
    .cp_rdata_out(cp_rdata_out), .cp_undef_out(cp_undef_out),
    .cp_hyp_trap_out(cp_hyp_trap_out), .el2_present_in(el2),
    .hyp_debug_access_trap_in(hyptr), .os_lock_state_in(lock),
    .inbound_buffer_occupied_in(live[8]),
    .outbound_buffer_occupied_in(live[7]),
    .inbound_overrun_flag_in(live[6]), .outbound_underrun_flag_in(live[5]),
    .interrupt_disable_copy_in(live[4:3]),
    .debug_access_trap_copy_in(live[2]), .halting_enable_copy_in(live[1]),
    .sticky_error_in(live[0]), .restore_strobe_out(restore_strobe_out),
    .inbound_buffer_occupied_out(ro[8]),
    .outbound_buffer_occupied_out(ro[7]),
    .inbound_overrun_flag_out(ro[6]), .outbound_underrun_flag_out(ro[5]),
    .interrupt_disable_copy_out(ro[4:3]),
    .debug_access_trap_copy_out(ro[2]), .halting_enable_copy_out(ro[1]),
    .sticky_error_out(ro[0]), .sw_software_breakpoint_instruction_in(ev[3]), .software_breakpoint_instruction_hit_in(ev[2]),
    .vcatch_hit_in(ev[1]), .watch_hit_in(ev[0]),
    .dbg_exc_take_out(dbg_exc_take_out),
    .dbg_exc_code_out(dbg_exc_code_out), .comms_valid_in(comms_valid_in),
    .comms_target_in(comms_target_in), .comms_form_in(comms_form_in),
    .debug_state_in(debug_state_in), .comms_undef_out(comms_undef_out),
    .monitor_debug_enable_out(mden), .user_comms_trap_out(uct));

  // clock, 100 ns period
  always #50 clk_in = ~clk_in;

  // expected read view built from live mirrors and the bench's state
  function automatic logic [31:0] view();
    return {1'h0, live[8:7], 1'h0, live[6:5], 2'h0, live[4:2], 2'h0,
      1'h1, 2'h0, mdbg, live[1], 1'h0, udcc, 5'h00, live[0], moe, 2'h0};
  endfunction

  task automatic chk(input string nm, input logic [35:0] s, x);
    compares++;
    if (s !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one access; valid stays up so calls may run back to back
  task automatic acc(input logic w, input logic [1:0] el,
                     input logic [17:0] en, input logic [31:0] wd);
    logic hy, ok, rd;
    @(negedge clk_in);
    hy = el == 2'h1 && el2 && hyptr;
    ok = en == HIT && el != 2'h0 && !hy;
    rd = ok && !w;
    if (ok && w && lock) begin
      rsf = {wd[30:29], wd[27:26], wd[23:21], wd[14], wd[6]};
    end
    if (en == HIT) begin
      e_q.push_back({rd, ok, el == 2'h0, hy,
        rd ? view() : {22'h00_0000, ok && w && lock, rsf}});
    end
    if (ok && w) begin
      {mdbg, udcc, moe} = {wd[15], wd[12], wd[5:2]};
    end
    {cp_valid_in, cp_write_in, el_in} = {1'h1, w, el};
    {enc, cp_wdata_in} = {en, wd};
    @(posedge clk_in);
  endtask

  task automatic idle();
    @(negedge clk_in);
    cp_valid_in = 1'h0;
  endtask

  // event request, expected code by priority and gating
  task automatic evt(input logic [3:0] v);
    logic [3:0] c;
    c = v[3] ? 4'h3 : !mdbg ? 4'h0 : v[2] ? 4'h1 : v[1] ? 4'h5 :
      v[0] ? 4'ha : 4'h0;
    @(negedge clk_in);
    ev = v;
    if (c != 4'h0) begin
      x_q.push_back(c);
      moe = c;
    end
    @(posedge clk_in);
  endtask

  // watcher: each answer takes the oldest queued expectation
  always @(negedge clk_in) begin
    if (cp_ack_out || cp_undef_out || cp_hyp_trap_out) begin
      e = e_q.size() ? e_q.pop_front() : 36'h0_0000_0000;
      chk("access", {e[35], cp_ack_out, cp_undef_out, cp_hyp_trap_out,
        e[35] ? cp_rdata_out : {22'h00_0000, restore_strobe_out, ro}},
        e);
    end
    if (dbg_exc_take_out) begin
      chk("entry", {32'h0, dbg_exc_code_out}, {32'h0, x_q.pop_front()});
    end
  end

  initial begin
    void'($urandom(94466));
    {mdbg, udcc, moe, rsf} = 0;
    repeat (5) @(posedge clk_in);
    @(negedge clk_in) rst_in = 1'h0;
    acc(1'h0, 2'h1, HIT, 32'h0);
    idle();
    chk("ctl", {34'h0, mden, uct}, 36'h0);
    $display("reset view test done");
    acc(1'h1, 2'h1, HIT, 32'h_FFFF_FFFF);
    acc(1'h0, 2'h2, HIT, 32'h0);
    idle();
    lock = 1'h1;
    repeat (8) begin
      live = 9'($urandom);
      acc(1'h1, 2'h1, HIT, $urandom);
      acc(1'h0, 2'h2, HIT, 32'h0);
      idle();
    end
    $display("lock test done");
    {el2, hyptr} = 2'h3;
    acc(1'h1, 2'h0, HIT, 32'h_0000_9000);
    acc(1'h0, 2'h1, HIT, 32'h0);
    acc(1'h1, 2'h2, HIT, 32'h_0000_8000);
    acc(1'h0, 2'h1, HIT ^ 18'h1, 32'h0);
    acc(1'h0, 2'h2, 18'h_3_C202, 32'h0);
    idle();
    {el2, hyptr} = 2'h0;
    $display("refusal test done");
    for (int m = 0; m < 2; m++) begin
      acc(1'h1, 2'h1, HIT, 32'(m) << 15);
      idle();
      for (int k = 0; k < 16; k++) evt(4'(k));
      @(negedge clk_in) ev = 4'h0;
      repeat (3) @(negedge clk_in);
      acc(1'h0, 2'h1, HIT, 32'h0);
      idle();
    end
    $display("event test done");
    for (int u = 0; u < 2; u++) begin
      acc(1'h1, 2'h1, HIT, 32'(u) << 12);
      idle();
      repeat (32) begin
        @(negedge clk_in);
        comms_target_in = dscr_target_t'($urandom_range(6));
        comms_form_in = dscr_form_t'($urandom_range(2));
        {comms_valid_in, debug_state_in} = 2'($urandom);
        el_in = 2'($urandom_range(2));
        #1;
        chk("comms", {35'h0, comms_undef_out}, {35'h0, comms_valid_in &&
          udcc && el_in == 2'h0 && comms_target_in != DSCR_TGT_OTHER &&
          !(debug_state_in && (comms_target_in == DSCR_TGT_INBOUND ||
          comms_target_in == DSCR_TGT_OUTBOUND))});
      end
    end
    $display("comms test done");
    acc(1'h1, 2'h1, HIT, 32'h_0000_9000);
    idle();
    rst_in = 1'h1;
    {mdbg, udcc, moe, rsf} = 0;
    repeat (2) @(negedge clk_in);
    rst_in = 1'h0;
    chk("ctl", {34'h0, mden, uct}, 36'h0);
    acc(1'h0, 2'h1, HIT, 32'h0);
    idle();
    repeat (3) @(negedge clk_in);
    chk("left", 36'(e_q.size() + x_q.size()), 36'h0);
    $display("mid reset test done");
    complete_run();
  end
endmodule
